// file: bcf_pkg.sv
// Constants, types and states of the bidirectional buffer
//
// Contract
// - Two independent 256x36 queues, opposite directions
// - Two 36-bit mailboxes, each with mail flag
// - Transfers only on own port clock edge
// - Flags two-stage synchronised to their port
// - Port-A almost-empty low when B-to-A count small
// - Port-B almost-empty low when A-to-B count small
// - Port-A almost-full low when A-to-B free small
// - Port-B almost-full low when B-to-A free small
// - Access needs select low and enable high
// - Data outputs float while select high
// - Reset release latches offset selects for presets
// - Joint release with selects low programs offsets
// - Input-ready low means full, writes ignored
// - Input-ready rises second write edge after reset
// - Port-A mailbox select picks mailbox or queue
// - Port-B mailbox select picks mailbox or queue
// - Port-A mailbox write lowers flag, blocks writes
// - Port-B mailbox read or reset raises flag
// - B-to-A mail flag mirrors with ports swapped
// - Output-ready high means word waits in register
// - Output-ready rises third read edge after fill
// - Presets are 64, 16 and 8
// - Program order Y1,X1,Y2,X2 from low byte
// - Queue write needs all enables and ready
`default_nettype none

package bcf_pkg;

  // Queue geometry
  localparam int unsigned DATA_W = 36;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DEPTH = 256;
  localparam int unsigned OFS_W = 8;
  localparam logic [9:0] DEPTH_CNT = 10'h100;

  // Preset offsets chosen at reset release
  localparam logic [7:0] PRESET_BOTH = 8'h40;
  localparam logic [7:0] PRESET_HIGH = 8'h10;
  localparam logic [7:0] PRESET_LOW = 8'h08;
  // Offset value after the block reset
  localparam logic [7:0] OFS_RST_VAL = 8'h08;

  // Register addresses on the bus
  localparam logic [7:0] ADR_OFFSETS = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;

  // Byte lanes of the offsets register
  localparam int unsigned LANE_AB_FULL = 0;
  localparam int unsigned LANE_AB_EMPTY = 1;
  localparam int unsigned LANE_BA_FULL = 2;
  localparam int unsigned LANE_BA_EMPTY = 3;

  // Sampled pins of one port
  typedef struct packed {
    logic select_n;
    logic enable;
    logic mbox;
    logic dir;
    logic [DATA_W-1:0] data;
  } bcf_port_s;

  // All pins passing the input synchroniser
  typedef struct packed {
    bcf_port_s a;
    bcf_port_s b;
    logic clk_a;
    logic clk_b;
    logic ab_rst_n;
    logic ba_rst_n;
    logic sel_low;
    logic sel_high;
  } bcf_pins_s;

  // Four status flags of one port
  typedef struct packed {
    logic ir;
    logic orr;
    logic ae_n;
    logic af_n;
  } bcf_flags_s;

  // Status register layout
  typedef struct packed {
    logic [20:0] zero;
    logic prog;
    logic ab_mail_n;
    logic ba_mail_n;
    bcf_flags_s a;
    bcf_flags_s b;
  } bcf_status_s;

  // Offset programming sequence, Gray along the path except the two-bit return from OFS_BA_EMPTY to OFS_RUN
  typedef enum logic [2:0] {
    OFS_RUN = 3'h0,
    OFS_AB_FULL = 3'h1,
    OFS_AB_EMPTY = 3'h3,
    OFS_BA_FULL = 3'h2,
    OFS_BA_EMPTY = 3'h6
  } bcf_ofs_e;

endpackage : bcf_pkg

`default_nettype wire

// file: bcf_queue.sv
// One 256x36 queue with output register and port-synchronised flags
`default_nettype none

module bcf_queue (
  // Clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic qrst_i,
  // Writing port
  input wire logic wr_edge_i,
  input wire logic wr_try_i,
  input wire logic [bcf_pkg::DATA_W-1:0] wr_data_i,
  input wire logic [bcf_pkg::OFS_W-1:0] full_ofs_i,
  input wire logic ir_hold_i,
  // Reading port
  input wire logic rd_edge_i,
  input wire logic rd_try_i,
  input wire logic [bcf_pkg::OFS_W-1:0] empty_ofs_i,
  // Flags and output register
  output logic ir_o,
  output logic or_o,
  output logic ae_n_o,
  output logic af_n_o,
  output logic [bcf_pkg::DATA_W-1:0] rd_data_o
);

  logic [bcf_pkg::DATA_W-1:0] mem [bcf_pkg::DEPTH]; // Storage array
  logic [bcf_pkg::ADDR_W:0] wptr_reg; // Write pointer, wrap bit on top
  logic [bcf_pkg::ADDR_W:0] rptr_reg; // Read pointer, wrap bit on top
  logic [bcf_pkg::ADDR_W:0] used; // Words in the array
  logic [9:0] count; // Words incl. output register
  logic [9:0] free; // Free array locations
  logic full; // Array full
  logic wr_do; // Write accepted this cycle
  logic pop; // Output register consumed
  logic ne1_reg, ne2_reg; // Not-empty sync stages
  logic ir1_reg, ir2_reg; // Input-ready sync stages
  logic ae1_reg, ae2_reg; // Almost-empty sync stages
  logic af1_reg, af2_reg; // Almost-full sync stages
  logic or_reg; // Word waits in output register
  logic [bcf_pkg::DATA_W-1:0] dout_reg; // Output register

  // Occupancy arithmetic
  assign used = wptr_reg - rptr_reg;
  assign full = used[bcf_pkg::ADDR_W];
  assign count = {1'b0, used} + {9'h000, or_reg};
  assign free = bcf_pkg::DEPTH_CNT - {1'b0, used};
  assign ir_o = ir2_reg & ~ir_hold_i;
  assign wr_do = wr_edge_i & wr_try_i & ir_o & ~full & ~qrst_i;
  assign pop = rd_edge_i & rd_try_i & or_reg;

  // Array write and write pointer
  always_ff @(posedge clk_i) begin
    if (rst_i || qrst_i) begin
      wptr_reg <= '0;
    end else if (wr_do) begin
      mem[wptr_reg[bcf_pkg::ADDR_W-1:0]] <= wr_data_i;
      wptr_reg <= wptr_reg + 9'h001;
    end
  end

  // Input-ready: up two write edges after reset, down when full
  always_ff @(posedge clk_i) begin
    if (rst_i || qrst_i) begin
      ir1_reg <= 1'b0;
      ir2_reg <= 1'b0;
    end else if (wr_do && used == 9'h0FF) begin
      ir1_reg <= 1'b0;
      ir2_reg <= 1'b0;
    end else if (wr_edge_i) begin
      ir1_reg <= ~full;
      ir2_reg <= ir1_reg;
    end
  end

  // Fall-through to the output register on the third read edge
  always_ff @(posedge clk_i) begin
    if (rst_i || qrst_i) begin
      ne1_reg <= 1'b0;
      ne2_reg <= 1'b0;
      or_reg <= 1'b0;
      rptr_reg <= '0;
      dout_reg <= '0;
    end else if (rd_edge_i) begin
      ne1_reg <= used != 9'h000;
      ne2_reg <= ne1_reg;
      if (!or_reg || pop) begin
        // Load only when the synced view and the array agree
        if (ne2_reg && used != 9'h000) begin
          dout_reg <= mem[rptr_reg[bcf_pkg::ADDR_W-1:0]];
          rptr_reg <= rptr_reg + 9'h001;
          or_reg <= 1'b1;
        end else begin
          or_reg <= 1'b0;
        end
      end
    end
  end

  // Almost-empty on the read clock, almost-full on the write clock
  always_ff @(posedge clk_i) begin
    if (rst_i || qrst_i) begin
      ae1_reg <= 1'b0;
      ae2_reg <= 1'b0;
      af1_reg <= 1'b1;
      af2_reg <= 1'b1;
    end else begin
      if (rd_edge_i) begin
        ae1_reg <= count > {2'b00, empty_ofs_i};
        ae2_reg <= ae1_reg;
      end
      if (wr_edge_i) begin
        af1_reg <= free > {2'b00, full_ofs_i};
        af2_reg <= af1_reg;
      end
    end
  end

  assign or_o = or_reg;
  assign ae_n_o = ae2_reg;
  assign af_n_o = af2_reg;
  assign rd_data_o = dout_reg;

endmodule : bcf_queue

`default_nettype wire

// file: bcf_buffer.sv
// Top of the bidirectional clocked buffer with mailboxes and bus slave
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`default_nettype none

module bcf_buffer (
  // System clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Port A control pins
  input wire logic port_a_clock_i,
  input wire logic port_a_select_n_i,
  input wire logic port_a_enable_i,
  input wire logic port_a_mailbox_select_i,
  input wire logic port_a_write_not_read_i,
  // Port A data pins
  input wire logic [35:0] port_a_data_bus_i,
  output logic [35:0] port_a_data_bus_o,
  output logic port_a_data_bus_oe_o,
  // Port A flags
  output logic port_a_input_ready_o,
  output logic port_a_output_ready_o,
  output logic port_a_almost_empty_n_o,
  output logic port_a_almost_full_n_o,
  // Port B control pins
  input wire logic port_b_clock_i,
  input wire logic port_b_select_n_i,
  input wire logic port_b_enable_i,
  input wire logic port_b_mailbox_select_i,
  input wire logic port_b_read_not_write_i,
  // Port B data pins
  input wire logic [35:0] port_b_data_bus_i,
  output logic [35:0] port_b_data_bus_o,
  output logic port_b_data_bus_oe_o,
  // Port B flags
  output logic port_b_input_ready_o,
  output logic port_b_output_ready_o,
  output logic port_b_almost_empty_n_o,
  output logic port_b_almost_full_n_o,
  // Mail flags
  output logic ab_mail_flag_n_o,
  output logic ba_mail_flag_n_o,
  // Queue resets and offset selects
  input wire logic ab_queue_reset_n_i,
  input wire logic ba_queue_reset_n_i,
  input wire logic offset_select_low_i,
  input wire logic offset_select_high_i
);

  bcf_pkg::bcf_pins_s pins; // Raw pin bundle
  bcf_pkg::bcf_pins_s pin1_reg; // First sync stage
  bcf_pkg::bcf_pins_s pin2_reg; // Second sync stage
  logic clk_a_prev_reg; // Port A clock, delayed
  logic clk_b_prev_reg; // Port B clock, delayed
  logic ab_rst_prev_reg; // A-to-B reset, delayed
  logic ba_rst_prev_reg; // B-to-A reset, delayed
  logic edge_a, edge_b; // Port clock rising edges
  logic ab_rel, ba_rel; // Queue reset releases
  logic ab_qrst, ba_qrst; // Queue resets held
  logic a_wr, a_rd, b_wr, b_rd; // Qualified port accesses
  logic ab_try, prog_wr; // Port A queue or offset write
  logic [7:0] ab_full_ofs_reg; // A-to-B full offset
  logic [7:0] ab_empty_ofs_reg; // A-to-B empty offset
  logic [7:0] ba_full_ofs_reg; // B-to-A full offset
  logic [7:0] ba_empty_ofs_reg; // B-to-A empty offset
  bcf_pkg::bcf_ofs_e ofs_state_reg; // Offset programming state
  logic [35:0] ab_mailbox_reg; // A-to-B mailbox
  logic [35:0] ba_mailbox_reg; // B-to-A mailbox
  logic ab_mail_n_reg; // Low while A-to-B mail waits
  logic ba_mail_n_reg; // Low while B-to-A mail waits
  logic [7:0] preset; // Preset for the latched selects
  logic [35:0] ab_q_data, ba_q_data; // Queue output registers
  logic [35:0] a_dout_reg, b_dout_reg; // Registered pin data
  logic a_oe_reg, b_oe_reg; // Registered pin enables
  logic ack_reg; // Bus acknowledge
  logic [31:0] rdata_reg; // Bus read data
  logic bus_req, bus_wr_ofs; // Bus request decode
  bcf_pkg::bcf_status_s status; // Live status word

  // Bundle every pin for the synchroniser
  assign pins.a = '{port_a_select_n_i, port_a_enable_i,
                    port_a_mailbox_select_i, port_a_write_not_read_i,
                    port_a_data_bus_i};
  assign pins.b = '{port_b_select_n_i, port_b_enable_i,
                    port_b_mailbox_select_i, port_b_read_not_write_i,
                    port_b_data_bus_i};
  assign pins.clk_a = port_a_clock_i;
  assign pins.clk_b = port_b_clock_i;
  assign pins.ab_rst_n = ab_queue_reset_n_i;
  assign pins.ba_rst_n = ba_queue_reset_n_i;
  assign pins.sel_low = offset_select_low_i;
  assign pins.sel_high = offset_select_high_i;

  // Two-flop synchroniser and edge history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin1_reg <= '0;
      pin2_reg <= '0;
      clk_a_prev_reg <= 1'b0;
      clk_b_prev_reg <= 1'b0;
      ab_rst_prev_reg <= 1'b0;
      ba_rst_prev_reg <= 1'b0;
    end else begin
      pin1_reg <= pins;
      pin2_reg <= pin1_reg;
      clk_a_prev_reg <= pin2_reg.clk_a;
      clk_b_prev_reg <= pin2_reg.clk_b;
      ab_rst_prev_reg <= pin2_reg.ab_rst_n;
      ba_rst_prev_reg <= pin2_reg.ba_rst_n;
    end
  end

  // Port clock edges and reset releases
  assign edge_a = pin2_reg.clk_a & ~clk_a_prev_reg;
  assign edge_b = pin2_reg.clk_b & ~clk_b_prev_reg;
  assign ab_rel = pin2_reg.ab_rst_n & ~ab_rst_prev_reg;
  assign ba_rel = pin2_reg.ba_rst_n & ~ba_rst_prev_reg;
  // Queue held in reset while its pin is low
  assign ab_qrst = ~pin2_reg.ab_rst_n;
  assign ba_qrst = ~pin2_reg.ba_rst_n;

  // Qualified accesses: select low, enable high, on own edge
  assign a_wr = edge_a & ~pin2_reg.a.select_n & pin2_reg.a.enable
              & pin2_reg.a.dir;
  assign a_rd = edge_a & ~pin2_reg.a.select_n & pin2_reg.a.enable
              & ~pin2_reg.a.dir;
  assign b_wr = edge_b & ~pin2_reg.b.select_n & pin2_reg.b.enable
              & ~pin2_reg.b.dir;
  assign b_rd = edge_b & ~pin2_reg.b.select_n & pin2_reg.b.enable
              & pin2_reg.b.dir;

  // Port A queue write goes to offsets while programming
  assign ab_try = a_wr & ~pin2_reg.a.mbox
                & (ofs_state_reg == bcf_pkg::OFS_RUN);
  assign prog_wr = a_wr & ~pin2_reg.a.mbox & port_a_input_ready_o
                 & (ofs_state_reg != bcf_pkg::OFS_RUN);
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign bus_wr_ofs = bus_req & wb_we_i & (wb_adr_i == bcf_pkg::ADR_OFFSETS);

  // Offset programming after a joint release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ofs_state_reg <= bcf_pkg::OFS_RUN;
    end else if (ab_qrst || ba_qrst) begin
      ofs_state_reg <= bcf_pkg::OFS_RUN;
    end else if (ab_rel && ba_rel && !pin2_reg.sel_low
                 && !pin2_reg.sel_high) begin
      ofs_state_reg <= bcf_pkg::OFS_AB_FULL;
    end else if (prog_wr) begin
      case (ofs_state_reg)
        bcf_pkg::OFS_AB_FULL: ofs_state_reg <= bcf_pkg::OFS_AB_EMPTY;
        bcf_pkg::OFS_AB_EMPTY: ofs_state_reg <= bcf_pkg::OFS_BA_FULL;
        bcf_pkg::OFS_BA_FULL: ofs_state_reg <= bcf_pkg::OFS_BA_EMPTY;
        default: ofs_state_reg <= bcf_pkg::OFS_RUN;
      endcase
    end
  end

  // Preset function of the two latched selects
  function automatic logic [7:0] preset_of(input logic hi, input logic lo);
    if (hi && lo) begin
      preset_of = bcf_pkg::PRESET_BOTH;
    end else if (hi) begin
      preset_of = bcf_pkg::PRESET_HIGH;
    end else begin
      preset_of = bcf_pkg::PRESET_LOW;
    end
  endfunction : preset_of
  assign preset = preset_of(pin2_reg.sel_high, pin2_reg.sel_low);

  // A-to-B offsets: preset, port A load, bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ab_full_ofs_reg <= bcf_pkg::OFS_RST_VAL;
      ab_empty_ofs_reg <= bcf_pkg::OFS_RST_VAL;
    end else if (ab_rel && (pin2_reg.sel_low || pin2_reg.sel_high)) begin
      ab_full_ofs_reg <= preset;
      ab_empty_ofs_reg <= preset;
    end else if (prog_wr) begin
      if (ofs_state_reg == bcf_pkg::OFS_AB_FULL) begin
        ab_full_ofs_reg <= pin2_reg.a.data[7:0];
      end
      if (ofs_state_reg == bcf_pkg::OFS_AB_EMPTY) begin
        ab_empty_ofs_reg <= pin2_reg.a.data[7:0];
      end
    end else if (bus_wr_ofs) begin
      if (wb_sel_i[bcf_pkg::LANE_AB_FULL]) begin
        ab_full_ofs_reg <= wb_dat_i[7:0];
      end
      if (wb_sel_i[bcf_pkg::LANE_AB_EMPTY]) begin
        ab_empty_ofs_reg <= wb_dat_i[15:8];
      end
    end
  end

  // B-to-A offsets, same priorities
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ba_full_ofs_reg <= bcf_pkg::OFS_RST_VAL;
      ba_empty_ofs_reg <= bcf_pkg::OFS_RST_VAL;
    end else if (ba_rel && (pin2_reg.sel_low || pin2_reg.sel_high)) begin
      ba_full_ofs_reg <= preset;
      ba_empty_ofs_reg <= preset;
    end else if (prog_wr) begin
      if (ofs_state_reg == bcf_pkg::OFS_BA_FULL) begin
        ba_full_ofs_reg <= pin2_reg.a.data[7:0];
      end
      if (ofs_state_reg == bcf_pkg::OFS_BA_EMPTY) begin
        ba_empty_ofs_reg <= pin2_reg.a.data[7:0];
      end
    end else if (bus_wr_ofs) begin
      if (wb_sel_i[bcf_pkg::LANE_BA_FULL]) begin
        ba_full_ofs_reg <= wb_dat_i[23:16];
      end
      if (wb_sel_i[bcf_pkg::LANE_BA_EMPTY]) begin
        ba_empty_ofs_reg <= wb_dat_i[31:24];
      end
    end
  end

  // A-to-B queue: written from A, read from B
  bcf_queue u_ab_queue (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .qrst_i(ab_qrst),
    .wr_edge_i(edge_a),
    .wr_try_i(ab_try),
    .wr_data_i(pin2_reg.a.data),
    .full_ofs_i(ab_full_ofs_reg),
    .ir_hold_i(1'b0),
    .rd_edge_i(edge_b),
    .rd_try_i(b_rd & ~pin2_reg.b.mbox),
    .empty_ofs_i(ab_empty_ofs_reg),
    .ir_o(port_a_input_ready_o),
    .or_o(port_b_output_ready_o),
    .ae_n_o(port_b_almost_empty_n_o),
    .af_n_o(port_a_almost_full_n_o),
    .rd_data_o(ab_q_data)
  );

  // B-to-A queue: input-ready held low while programming
  bcf_queue u_ba_queue (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .qrst_i(ba_qrst),
    .wr_edge_i(edge_b),
    .wr_try_i(b_wr & ~pin2_reg.b.mbox),
    .wr_data_i(pin2_reg.b.data),
    .full_ofs_i(ba_full_ofs_reg),
    .ir_hold_i(ofs_state_reg != bcf_pkg::OFS_RUN),
    .rd_edge_i(edge_a),
    .rd_try_i(a_rd & ~pin2_reg.a.mbox),
    .empty_ofs_i(ba_empty_ofs_reg),
    .ir_o(port_b_input_ready_o),
    .or_o(port_a_output_ready_o),
    .ae_n_o(port_a_almost_empty_n_o),
    .af_n_o(port_b_almost_full_n_o),
    .rd_data_o(ba_q_data)
  );

  // A-to-B mailbox; a write beats a same-cycle read
  always_ff @(posedge clk_i) begin
    if (rst_i || ab_qrst) begin
      ab_mail_n_reg <= 1'b1;
      ab_mailbox_reg <= '0;
    end else if (a_wr && pin2_reg.a.mbox && ab_mail_n_reg) begin
      ab_mailbox_reg <= pin2_reg.a.data;
      ab_mail_n_reg <= 1'b0;
    end else if (b_rd && pin2_reg.b.mbox) begin
      ab_mail_n_reg <= 1'b1;
    end
  end

  // B-to-A mailbox and its flag
  always_ff @(posedge clk_i) begin
    if (rst_i || ba_qrst) begin
      ba_mail_n_reg <= 1'b1;
      ba_mailbox_reg <= '0;
    end else if (b_wr && pin2_reg.b.mbox && ba_mail_n_reg) begin
      ba_mailbox_reg <= pin2_reg.b.data;
      ba_mail_n_reg <= 1'b0;
    end else if (a_rd && pin2_reg.a.mbox) begin
      ba_mail_n_reg <= 1'b1;
    end
  end

  // Registered pin drivers, enabled while read-selected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_dout_reg <= '0;
      b_dout_reg <= '0;
      a_oe_reg <= 1'b0;
      b_oe_reg <= 1'b0;
    end else begin
      a_dout_reg <= pin2_reg.a.mbox ? ba_mailbox_reg : ba_q_data;
      b_dout_reg <= pin2_reg.b.mbox ? ab_mailbox_reg : ab_q_data;
      a_oe_reg <= ~pin2_reg.a.select_n & ~pin2_reg.a.dir;
      b_oe_reg <= ~pin2_reg.b.select_n & pin2_reg.b.dir;
    end
  end

  // Live status word
  assign status.zero = '0;
  assign status.prog = ofs_state_reg != bcf_pkg::OFS_RUN;
  assign status.ab_mail_n = ab_mail_n_reg;
  assign status.ba_mail_n = ba_mail_n_reg;
  assign status.a = '{port_a_input_ready_o, port_a_output_ready_o,
                      port_a_almost_empty_n_o, port_a_almost_full_n_o};
  assign status.b = '{port_b_input_ready_o, port_b_output_ready_o,
                      port_b_almost_empty_n_o, port_b_almost_full_n_o};

  // Bus slave: one-cycle ack after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg <= bus_req;
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i)
          bcf_pkg::ADR_OFFSETS: rdata_reg <= {ba_empty_ofs_reg,
                                              ba_full_ofs_reg,
                                              ab_empty_ofs_reg,
                                              ab_full_ofs_reg};
          bcf_pkg::ADR_STATUS: rdata_reg <= status;
          default: rdata_reg <= '0;
        endcase
      end
    end
  end

  // Outputs
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign port_a_data_bus_o = a_dout_reg;
  assign port_a_data_bus_oe_o = a_oe_reg;
  assign port_b_data_bus_o = b_dout_reg;
  assign port_b_data_bus_oe_o = b_oe_reg;
  assign ab_mail_flag_n_o = ab_mail_n_reg;
  assign ba_mail_flag_n_o = ba_mail_n_reg;

endmodule : bcf_buffer

`default_nettype wire

// file: bcf_buffer_props.sv
// Port-level checker for the bidirectional buffer
`default_nettype none
module bcf_buffer_props (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Port selects and data enables
  input wire logic port_a_select_n_i,
  input wire logic port_b_select_n_i,
  input wire logic port_a_data_bus_oe_o,
  input wire logic port_b_data_bus_oe_o,
  // Queue resets and flags
  input wire logic ab_queue_reset_n_i,
  input wire logic ba_queue_reset_n_i,
  input wire logic port_a_input_ready_o,
  input wire logic port_b_input_ready_o,
  input wire logic port_a_output_ready_o,
  input wire logic port_b_output_ready_o,
  input wire logic ab_mail_flag_n_o,
  input wire logic ba_mail_flag_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request answered next cycle
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  // Ack is a single-cycle pulse
  property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack1: assert property (p_ack1) else $error("ack too long");
  // Port deselected for four cycles never drives
  property p_oe_a; port_a_select_n_i [*4] |->
    !port_a_data_bus_oe_o; endproperty
  a_oe_a: assert property (p_oe_a) else $error("port A drives");
  property p_oe_b; port_b_select_n_i [*4] |->
    !port_b_data_bus_oe_o; endproperty
  a_oe_b: assert property (p_oe_b) else $error("port B drives");
  // Held queue reset forces its flags
  property p_ab_rst; !ab_queue_reset_n_i [*8] |-> !port_a_input_ready_o &&
    !port_b_output_ready_o && ab_mail_flag_n_o; endproperty
  a_ab_rst: assert property (p_ab_rst)
    else $error("ab reset");
  property p_ba_rst; !ba_queue_reset_n_i [*8] |-> !port_b_input_ready_o &&
    !port_a_output_ready_o && ba_mail_flag_n_o; endproperty
  a_ba_rst: assert property (p_ba_rst)
    else $error("ba reset");
  // Mail waits while reader idle
  property p_ab_hold; (port_b_select_n_i && ab_queue_reset_n_i) [*6]
    ##0 !ab_mail_flag_n_o |=> !ab_mail_flag_n_o; endproperty
  a_ab_hold: assert property (p_ab_hold) else $error("ab mail lost");
  property p_ba_hold; (port_a_select_n_i && ba_queue_reset_n_i) [*6]
    ##0 !ba_mail_flag_n_o |=> !ba_mail_flag_n_o; endproperty
  a_ba_hold: assert property (p_ba_hold) else $error("ba mail lost");
endmodule : bcf_buffer_props
bind bcf_buffer bcf_buffer_props u_bcf_buffer_props (.*);
`default_nettype wire

// file: bcf_port_model.sv
// Far side of one port: free clock, control and data pins
`default_nettype none
module bcf_port_model #(
  parameter int HALF = 5,
  parameter bit RD_HI = 1'b0
) (
  // System clock and resolved data wire
  input wire logic clk_i,
  input wire logic [35:0] bus_i,
  // Pins driven toward the port
  output logic pclk_o,
  output logic sel_n_o,
  output logic en_o,
  output logic mb_o,
  output logic dir_o,
  output logic [35:0] drv_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0; // Half-period counter
  initial begin
    {pclk_o, sel_n_o, en_o, mb_o, dir_o} = 5'h08;
    drv_o = 36'h0;
  end
  // Free-running port clock
  always @(posedge clk_i) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) pclk_o <= ~pclk_o;
  end
  // One access, held through its port edge
  task automatic xfer(input logic w, input logic mb, input logic [35:0] d,
                      output logic [35:0] q);
    @(posedge pclk_o);
    @(posedge clk_i);
    {sel_n_o, en_o, mb_o, dir_o} <= {2'h1, mb, w ^ RD_HI};
    if (w) drv_o <= d;
    @(posedge pclk_o);
    q = bus_i;
    @(posedge clk_i);
    {sel_n_o, en_o} <= 2'h2;
    drv_o <= ~drv_o; // No stale word on release
  endtask : xfer
endmodule : bcf_port_model
`default_nettype wire

// file: bcf_buffer_tb.sv
// Self-checking bench for the bidirectional buffer
`default_nettype none
module bcf_buffer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, wq;
  logic port_a_clock_i, port_a_select_n_i, port_a_enable_i;
  logic port_a_mailbox_select_i, port_a_write_not_read_i;
  logic port_b_clock_i, port_b_select_n_i, port_b_enable_i;
  logic port_b_mailbox_select_i, port_b_read_not_write_i;
  logic [35:0] port_a_data_bus_i, port_a_data_bus_o, a_drv, d;
  logic [35:0] port_b_data_bus_i, port_b_data_bus_o, b_drv, q;
  logic port_a_data_bus_oe_o, port_b_data_bus_oe_o, ab_mail_flag_n_o;
  logic port_a_input_ready_o, port_a_output_ready_o, ba_mail_flag_n_o;
  logic port_a_almost_empty_n_o, port_a_almost_full_n_o;
  logic port_b_input_ready_o, port_b_output_ready_o;
  logic port_b_almost_empty_n_o, port_b_almost_full_n_o;
  logic ab_queue_reset_n_i = 1'b1, ba_queue_reset_n_i = 1'b1;
  logic offset_select_low_i = 1'b0, offset_select_high_i = 1'b0;
  logic [7:0] pre [4] = '{8'h00, bcf_pkg::PRESET_LOW,
    bcf_pkg::PRESET_HIGH, bcf_pkg::PRESET_BOTH};
  int fails = 0, n_tests = 0;
  always #20 clk_i = ~clk_i;
  // Wire levels from both parties
  assign port_a_data_bus_i = port_a_data_bus_oe_o ? port_a_data_bus_o : a_drv;
  assign port_b_data_bus_i = port_b_data_bus_oe_o ? port_b_data_bus_o : b_drv;
  bcf_buffer u_bcf_buffer (.*);
  bcf_port_model #(.HALF(5), .RD_HI(1'b0)) u_bcf_port_model_a (.clk_i,
    .bus_i(port_a_data_bus_i), .pclk_o(port_a_clock_i),
    .sel_n_o(port_a_select_n_i), .en_o(port_a_enable_i),
    .mb_o(port_a_mailbox_select_i), .dir_o(port_a_write_not_read_i),
    .drv_o(a_drv));
  bcf_port_model #(.HALF(7), .RD_HI(1'b1)) u_bcf_port_model_b (.clk_i,
    .bus_i(port_b_data_bus_i), .pclk_o(port_b_clock_i),
    .sel_n_o(port_b_select_n_i), .en_o(port_b_enable_i),
    .mb_o(port_b_mailbox_select_i), .dir_o(port_b_read_not_write_i),
    .drv_o(b_drv));
  // Count and report one comparison
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One Wishbone cycle, read data into wq
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
    wb_adr_i <= a;
    wb_dat_i <= v;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wq = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask : wb
  // Reset both queues with offset selects fs
  task automatic qrst(input logic [1:0] fs);
    @(posedge clk_i);
    {offset_select_high_i, offset_select_low_i} <= fs;
    {ab_queue_reset_n_i, ba_queue_reset_n_i} <= 2'h0;
    repeat (5) @(posedge port_b_clock_i);
    @(posedge clk_i);
    {ab_queue_reset_n_i, ba_queue_reset_n_i} <= 2'h3;
    wait (port_a_input_ready_o === 1'b1);
  endtask : qrst
  // Access port B if s, else port A
  task automatic go(input logic s, input logic w, input logic mb);
    if (s) u_bcf_port_model_b.xfer(w, mb, d, q);
    else u_bcf_port_model_a.xfer(w, mb, d, q);
  endtask : go
  // Verdict and end of run
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 1; i < 4; i++) begin
      qrst(2'(i));
      wb(1'b0, bcf_pkg::ADR_OFFSETS, 32'h0);
      chk(36'(wq), 36'({4{pre[i]}}));
      chk(36'({port_a_almost_empty_n_o,
        port_a_almost_full_n_o, port_b_almost_empty_n_o,
        port_b_almost_full_n_o}), 36'h5);
    end
    wb(1'b1, bcf_pkg::ADR_OFFSETS, 32'h0C0B0A09);
    wb(1'b0, bcf_pkg::ADR_OFFSETS, 32'h0);
    chk(36'(wq), 36'h0C0B0A09);
    wb(1'b0, 8'h08, 32'h0);
    chk(36'(wq), 36'h0);
    qrst(2'h0);
    wb(1'b0, bcf_pkg::ADR_STATUS, 32'h0);
    chk(36'({wq[10], port_b_input_ready_o}), 36'h2);
    for (int k = 0; k < 4; k++) begin
      d = 36'hF_FFFF_FF10 + 36'(k);
      go(1'b0, 1'b1, 1'b0);
    end
    wait (port_b_input_ready_o === 1'b1);
    wb(1'b0, bcf_pkg::ADR_OFFSETS, 32'h0);
    chk(36'(wq), 36'h13121110);
    for (int s = 0; s < 2; s++) for (int m = 0; m < 2; m++) begin
      d = 36'h9_8765_4320 | 36'(s * 2 + m);
      go(1'(s), 1'b1, 1'(m));
      wait ((s ? (m ? !ba_mail_flag_n_o : port_a_output_ready_o)
        : (m ? !ab_mail_flag_n_o : port_b_output_ready_o)) === 1'b1);
      d = ~d;
      if (m) go(1'(s), 1'b1, 1'b1);
      d = ~d;
      go(!1'(s), 1'b0, 1'(m));
      chk(q, d);
      wait ((s ? ba_mail_flag_n_o : ab_mail_flag_n_o) === 1'b1);
    end
    close_out();
  end
  // Watchdog, far past a normal run
  initial begin
    #400000;
    fails++;
    close_out();
  end
endmodule : bcf_buffer_tb
`default_nettype wire
